/* File: testbench/tci_bus_master.sv */
// Bus master model for the touch controller register port: makes clock and data.
// Assumes an open-drain data wire with a pull-up, resolved by the bench.
`timescale 1ns/1ps
module tci_bus_master (
   input  wire logic clk_sys,
   input  wire logic sda_line,
   output logic      scl_drv,
   output logic      sda_drv
);
   // A quarter bit of 7 cycles gives 28 cycles a bit, about 357 kbit/s.
   localparam int Q = 7;

   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic wq();
      repeat (Q) @(posedge clk_sys);
   endtask

   // Serves as first and as repeated start; only this model opens a transfer.
   task automatic start();
      sda_drv <= 1'b1;
      wq();
      scl_drv <= 1'b1;
      wq();
      sda_drv <= 1'b0;
      wq();
      scl_drv <= 1'b0;
      wq();
   endtask

   task automatic stop();
      sda_drv <= 1'b0;
      wq();
      scl_drv <= 1'b1;
      wq();
      sda_drv <= 1'b1;
      wq();
   endtask

   // Data is changed in mid-low and sampled in mid-high.
   task automatic bit_io(input logic b, output logic s);
      wq();
      sda_drv <= b;
      wq();
      scl_drv <= 1'b1;
      wq();
      s = sda_line;
      wq();
      scl_drv <= 1'b0;
   endtask

   // A one in the ninth bit releases the wire so the device can answer.
   task automatic byte_io(input logic [7:0] d, input logic last,
                          output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r[i]);
      bit_io(last, ack);
   endtask
endmodule

/* File: testbench/tci_i2c_slave_tb.sv */
// Self-checking bench of the touch controller register port.
// Assumes the bus master model and an open-drain data wire with pull-up.
`timescale 1ns/1ps
`include "tci_params.svh"
module tci_i2c_slave_tb import tci_pkg::*; ();
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  rexp;
   } tci_row_s;

   logic       clk_sys, reset, clk_en, addr_sel;
   logic       scl_m, sda_m, sda_out, sda_oe, addr_alt, busy, cmd_strobe;
   logic [7:0] cmd_value, r;
   logic       a, scl_q, oe_q;
   tci_cfg_s   cfg;
   wire        sda_in = sda_m & ~(sda_oe & ~sda_out);
   int         err_total, n_checks, n_strobe;
   logic [7:0] wbuf [4];
   logic [7:0] gbuf [8];
   logic [7:0] bexp [6] = '{8'h5A, 8'h11, 8'h22, 8'h33, 8'h44, 8'h05};
   tci_row_s   rows [5] = '{
      '{`TCI_REG_CFG_VER, 8'h5A, 8'h5A}, '{`TCI_REG_TOUCH, 8'h05, 8'h05},
      '{`TCI_REG_SWITCH1, 8'hC3, 8'hC3}, '{`TCI_REG_COMMAND, 8'h01, `TCI_RD_FILL},
      '{16'h8050, 8'h77, `TCI_RD_FILL}};

   tci_bus_master i_master (
      .clk_sys  (clk_sys),
      .sda_line (sda_in),
      .scl_drv  (scl_m),
      .sda_drv  (sda_m)
   );

   tci_i2c_slave i_dut (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .clk_en     (clk_en),
      .scl_in     (scl_m),
      .sda_in     (sda_in),
      .addr_sel   (addr_sel),
      .sda_out    (sda_out),
      .sda_oe     (sda_oe),
      .addr_alt   (addr_alt),
      .busy       (busy),
      .cfg        (cfg),
      .cmd_strobe (cmd_strobe),
      .cmd_value  (cmd_value)
   );

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic complete_run();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [55:0] got, input logic [55:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Device address and pointer, then n bytes of wbuf; fin closes with a stop.
   task automatic xfer_wr(input logic [7:0] dev, input logic [15:0] ptr,
                          input int n, input logic fin);
      i_master.start();
      i_master.byte_io(dev, 1'b1, r, a);
      chk(a, 1'b0);
      i_master.byte_io(ptr[15:8], 1'b1, r, a);
      chk(a, 1'b0);
      i_master.byte_io(ptr[7:0], 1'b1, r, a);
      chk(a, 1'b0);
      for (int i = 0; i < n; i++) begin
         i_master.byte_io(wbuf[i], 1'b1, r, a);
         chk(a, 1'b0);
      end
      if (fin)
         i_master.stop();
   endtask

   task automatic xfer_rd(input logic [7:0] dev, input logic [15:0] ptr, input int n);
      xfer_wr(dev, ptr, 0, 1'b0);
      i_master.start();
      i_master.byte_io(dev | 8'h01, 1'b1, r, a);
      chk(a, 1'b0);
      for (int i = 0; i < n; i++)
         i_master.byte_io(8'hFF, i == n - 1, gbuf[i], a);
      i_master.stop();
   endtask

   task automatic refused(input logic [7:0] dev);
      i_master.start();
      i_master.byte_io(dev, 1'b1, r, a);
      chk(a, 1'b1);
      i_master.byte_io(8'h80, 1'b1, r, a);
      chk(a, 1'b1);
      i_master.stop();
   endtask

   task automatic do_reset(input logic sel);
      @(posedge clk_sys);
      reset    <= 1'b1;
      addr_sel <= sel;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   // The device may move its data drive only while the clock is low.
   always @(posedge clk_sys) begin
      if (cmd_strobe === 1'b1)
         n_strobe++;
      if (scl_m && scl_q && sda_oe !== oe_q) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, sda_oe, oe_q);
      end
      scl_q <= scl_m;
      oe_q  <= sda_oe;
   end

   initial begin
      repeat (80000) @(posedge clk_sys);
      err_total++;
      complete_run();
   end

   initial begin
      reset    = 1'b1;
      clk_en   = 1'b1;
      addr_sel = 1'b0;
      scl_q    = 1'b1;
      oe_q     = 1'b0;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk(cfg, 56'h0);
      chk({sda_out, sda_oe, busy, addr_alt, cmd_strobe, cmd_value}, 56'h0);
      foreach (rows[k]) begin
         wbuf[0] = rows[k].wdata;
         xfer_wr(`TCI_ADDR_W_PRI, rows[k].addr, 1, 1'b1);
         xfer_rd(`TCI_ADDR_W_PRI, rows[k].addr, 1);
         chk(gbuf[0], rows[k].rexp);
      end
      chk(cfg.config_version, 8'h5A);
      chk(cfg.max_touch_points, 8'h05);
      chk(cfg.feature_switch_one, 8'hC3);
      chk(cmd_value, 8'h01);
      chk(n_strobe, 1);
      wbuf = '{8'h11, 8'h22, 8'h33, 8'h44};
      xfer_wr(`TCI_ADDR_W_PRI, `TCI_REG_X_LO, 4, 1'b1);
      chk(cfg.x_resolution, 16'h2211);
      chk(cfg.y_resolution, 16'h4433);
      xfer_rd(`TCI_ADDR_W_PRI, `TCI_REG_CFG_VER, 6);
      for (int i = 0; i < 6; i++)
         chk(gbuf[i], bexp[i]);
      // A read without a pointer write continues where the last read stopped.
      i_master.start();
      i_master.byte_io(`TCI_ADDR_W_PRI | 8'h01, 1'b1, r, a);
      chk(a, 1'b0);
      i_master.byte_io(8'hFF, 1'b1, r, a);
      i_master.stop();
      chk(r, 8'hC3);
      chk(busy, 1'b0);
      refused(`TCI_ADDR_W_ALT);
      refused(8'h50);
      // With the clock enable low the device must not answer its own address.
      clk_en <= 1'b0;
      refused(`TCI_ADDR_W_PRI);
      chk({busy, sda_oe}, 56'h0);
      clk_en <= 1'b1;
      do_reset(1'b1);
      chk(addr_alt, 1'b1);
      chk(cfg, 56'h0);
      wbuf[0] = 8'h9C;
      xfer_wr(`TCI_ADDR_W_ALT, `TCI_REG_CFG_VER, 1, 1'b1);
      xfer_rd(`TCI_ADDR_W_ALT, `TCI_REG_CFG_VER, 1);
      chk(gbuf[0], 8'h9C);
      refused(`TCI_ADDR_W_PRI);
      complete_run();
   end
endmodule

/* File: verilog/tci_i2c_slave.sv */
// Serial register port of the touch controller: target-only two-wire bus engine.
// Assumes a bus master outside, an open-drain data wire resolved by the bench,
// and line inputs synchronous to clk_sys.
`timescale 1ns/1ps
`include "tci_params.svh"

module tci_i2c_slave import tci_pkg::*; (
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       clk_en,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       addr_sel,
   output logic            sda_out,
   output logic            sda_oe,
   output logic            addr_alt,
   output logic            busy,
   output tci_cfg_s        cfg,
   output logic            cmd_strobe,
   output logic      [7:0] cmd_value
);

   localparam int RESP_CYC_MAX = `TCI_BIT_CYC / 4;

   tci_line_s   line;
   tci_wr_s     wr;
   tci_state_e  state;
   tci_phase_e  phase;
   logic [3:0]  bit_cnt;
   logic [7:0]  shift;
   logic [15:0] ptr;
   logic        rw_read;
   logic        master_nack;
   logic        strap_taken;
   logic [7:0]  rd_data;

   tci_line_monitor u_line (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .line    (line)
   );

   tci_reg_file u_regs (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .clk_en     (clk_en),
      .wr         (wr),
      .rd_addr    (ptr),
      .rd_data    (rd_data),
      .cfg        (cfg),
      .cmd_strobe (cmd_strobe),
      .cmd_value  (cmd_value)
   );

   wire logic [7:0] own_addr   = addr_alt ? `TCI_ADDR_W_ALT : `TCI_ADDR_W_PRI;
   wire logic       addr_match = (shift[7:1] == own_addr[7:1]);
   wire logic       byte_full  = (bit_cnt == `TCI_BITS_PER_BYTE);
   wire logic       ninth_fall = (state == st_rx_byte) && line.scl_fall && byte_full;
   wire logic       tx_done    = (state == st_tx_byte) && line.scl_fall && byte_full;
   wire tci_phase_e next_phase = (phase == ph_addr)   ? ph_ptr_hi :
                                 (phase == ph_ptr_hi) ? ph_ptr_lo : ph_data;

   // Each received data byte is handed to the register file at the current pointer.
   assign wr.en   = ninth_fall && (phase == ph_data);
   assign wr.addr = ptr;
   assign wr.data = shift;

   // The address strap is caught once, in the first enabled cycle after reset.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         strap_taken <= 1'b0;
         addr_alt    <= 1'b0;
      end else if (clk_en && !strap_taken) begin
         strap_taken <= 1'b1;
         addr_alt    <= addr_sel;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sda_out <= 1'b0;
         busy    <= 1'b0;
      end else if (clk_en) begin
         sda_out <= 1'b0;
         busy    <= (state != st_idle);
      end
   end

   // Protocol engine. Drive changes happen one cycle after a detected falling
   // clock edge, so data is steady across the whole high phase of the clock.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state       <= st_idle;
         phase       <= ph_addr;
         bit_cnt     <= 4'h0;
         shift       <= 8'h00;
         ptr         <= 16'h0000;
         rw_read     <= 1'b0;
         master_nack <= 1'b0;
         sda_oe      <= 1'b0;
      end else if (clk_en) begin
         if (line.start) begin
            state   <= st_rx_byte;
            phase   <= ph_addr;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
         end else if (line.stop) begin
            state  <= st_idle;
            sda_oe <= 1'b0;
         end else begin
            case (state)
               st_idle: begin
                  sda_oe <= 1'b0;
               end
               st_rx_byte: begin
                  if (line.scl_rise) begin
                     shift   <= {shift[6:0], line.sda};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (ninth_fall) begin
                     if (phase == ph_addr && !addr_match) begin
                        state <= st_idle;
                     end else begin
                        state  <= st_rx_ack;
                        sda_oe <= 1'b1;
                     end
                     if (phase == ph_addr) begin
                        rw_read <= shift[0];
                     end
                     if (phase == ph_ptr_hi) begin
                        ptr[15:8] <= shift;
                     end
                     if (phase == ph_ptr_lo) begin
                        ptr[7:0] <= shift;
                     end
                  end
               end
               st_rx_ack: begin
                  if (line.scl_fall) begin
                     bit_cnt <= 4'h0;
                     if (phase == ph_addr && rw_read) begin
                        state  <= st_tx_byte;
                        phase  <= ph_data;
                        shift  <= rd_data;
                        sda_oe <= ~rd_data[7];
                     end else begin
                        state  <= st_rx_byte;
                        sda_oe <= 1'b0;
                        phase  <= next_phase;
                        if (phase == ph_data) begin
                           ptr <= ptr + 16'h0001;
                        end
                     end
                  end
               end
               st_tx_byte: begin
                  if (line.scl_rise) begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (tx_done) begin
                     state  <= st_tx_ack;
                     sda_oe <= 1'b0;
                     ptr    <= ptr + 16'h0001;
                  end else if (line.scl_fall) begin
                     shift  <= {shift[6:0], 1'b0};
                     sda_oe <= ~shift[6];
                  end
               end
               st_tx_ack: begin
                  if (line.scl_rise) begin
                     master_nack <= line.sda;
                  end else if (line.scl_fall) begin
                     bit_cnt <= 4'h0;
                     if (master_nack) begin
                        state <= st_idle;
                     end else begin
                        state  <= st_tx_byte;
                        shift  <= rd_data;
                        sda_oe <= ~rd_data[7];
                     end
                  end
               end
               default: begin
                  state  <= st_idle;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset || !clk_en);

   sequence s_addr_done;
      ninth_fall && (phase == ph_addr);
   endsequence

   sequence s_ack_held;
      sda_oe && (state == st_rx_ack);
   endsequence

   a_addr_ack: assert property (s_addr_done ##0 addr_match |=> s_ack_held)
      else $error("matching address was not acknowledged");

   a_addr_ignore: assert property (
      s_addr_done ##0 !addr_match |=> (state == st_idle) && !sda_oe)
      else $error("mismatched address did not return to idle");

   a_drive_addressed: assert property (sda_oe |-> state != st_idle)
      else $error("data driven while not addressed");

   a_strap_fixed: assert property (strap_taken |=> $stable(addr_alt))
      else $error("address selection changed after power-on");

   a_start_restart: assert property (
      line.start |=> (state == st_rx_byte) && (phase == ph_addr) && (bit_cnt == 4'h0))
      else $error("start did not restart the address byte");

   a_stop_idle: assert property (line.stop |=> (state == st_idle) && !sda_oe)
      else $error("stop did not return to idle");

   a_unit_bits: assert property (bit_cnt <= `TCI_BITS_PER_BYTE)
      else $error("bit counter passed eight");

   a_oe_clock_low: assert property (
      $changed(sda_oe) && !$past(line.start) && !$past(line.stop) |-> !line.scl)
      else $error("data drive changed while clock high");

   a_tx_bit_prompt: assert property (
      line.scl_fall && (state == st_tx_byte) && !byte_full
      |-> ##[1:RESP_CYC_MAX] (sda_oe == !shift[7]))
      else $error("next read bit not presented in time");

   a_ptr_low_load: assert property (
      ninth_fall && (phase == ph_ptr_lo) |=> ptr[7:0] == $past(shift))
      else $error("pointer low byte not loaded");

   a_ptr_write_inc: assert property (
      (state == st_rx_ack) && line.scl_fall && (phase == ph_data)
      |=> ptr == $past(ptr) + 16'h0001)
      else $error("pointer did not advance after written byte");

   a_ptr_read_inc: assert property (
      tx_done |=> (ptr == $past(ptr) + 16'h0001) && (state == st_tx_ack) && !sda_oe)
      else $error("pointer did not advance after read byte");

   a_nack_end: assert property (
      (state == st_tx_ack) && line.scl_fall && master_nack |=> (state == st_idle) && !sda_oe)
      else $error("read did not end after master not-acknowledge");

   sequence s_read_turn;
      (state == st_rx_ack) && line.scl_fall && (phase == ph_addr) && rw_read;
   endsequence

   sequence s_bit_shown;
      (state == st_tx_byte) && (sda_oe == !shift[7]);
   endsequence

   a_ack_release: assert property (
      (state == st_rx_ack) && line.scl_fall && !((phase == ph_addr) && rw_read)
      |=> (state == st_rx_byte) && !sda_oe && (bit_cnt == 4'h0))
      else $error("acknowledge not released after ninth clock");

   a_read_turn: assert property (
      s_read_turn |=> s_bit_shown ##0 (phase == ph_data))
      else $error("first read bit not presented after read address");

   a_next_byte: assert property (
      (state == st_tx_ack) && line.scl_fall && !master_nack
      |=> s_bit_shown ##0 (bit_cnt == 4'h0))
      else $error("next read byte not started after master acknowledge");

   a_ptr_high_load: assert property (
      ninth_fall && (phase == ph_ptr_hi) |=> ptr[15:8] == $past(shift))
      else $error("pointer high byte not loaded");

   a_rx_sample: assert property (
      (state == st_rx_byte) && line.scl_rise
      |=> (shift[0] == $past(line.sda)) && (bit_cnt == $past(bit_cnt) + 4'h1))
      else $error("received bit not shifted in");

   a_busy_follow: assert property (busy == $past(state != st_idle))
      else $error("busy did not follow the engine state");

   a_idle_silent: assert property ((state == st_idle) |=> !sda_oe)
      else $error("data driven from idle");

endmodule

/* File: verilog/tci_line_monitor.sv */
// Samples the serial clock and data lines and flags edges, start and stop.
// Assumes the line inputs are synchronous to clk_sys.
`timescale 1ns/1ps
module tci_line_monitor import tci_pkg::*; (
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic clk_en,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output tci_line_s line
);

   logic scl_q;
   logic sda_q;
   logic scl_p;
   logic sda_p;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else if (clk_en) begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         scl_p <= scl_q;
         sda_p <= sda_q;
      end
   end

   assign line.scl      = scl_q;
   assign line.sda      = sda_q;
   assign line.scl_rise = scl_q & ~scl_p;
   assign line.scl_fall = ~scl_q & scl_p;
   assign line.start    = scl_q & scl_p & sda_p & ~sda_q;
   assign line.stop     = scl_q & scl_p & ~sda_p & sda_q;

endmodule

/* File: verilog/tci_params.svh */
// Constants of the touch controller register port: addresses, offsets, resets, timing.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef TCI_PARAMS_SVH
`define TCI_PARAMS_SVH

`define TCI_CLK_HZ         10000000
`define TCI_BIT_RATE_MAX   400000
`define TCI_BIT_CYC        (`TCI_CLK_HZ / `TCI_BIT_RATE_MAX)
`define TCI_BITS_PER_BYTE  4'h8

`define TCI_ADDR_W_PRI     8'hBA
`define TCI_ADDR_W_ALT     8'h28

`define TCI_REG_COMMAND    16'h8040
`define TCI_REG_CFG_VER    16'h8047
`define TCI_REG_X_LO       16'h8048
`define TCI_REG_X_HI       16'h8049
`define TCI_REG_Y_LO       16'h804A
`define TCI_REG_Y_HI       16'h804B
`define TCI_REG_TOUCH      16'h804C
`define TCI_REG_SWITCH1    16'h804D

`define TCI_RST_COMMAND    8'h00
`define TCI_RST_CFG_VER    8'h00
`define TCI_RST_X_LO       8'h00
`define TCI_RST_X_HI       8'h00
`define TCI_RST_Y_LO       8'h00
`define TCI_RST_Y_HI       8'h00
`define TCI_RST_TOUCH      8'h00
`define TCI_RST_SWITCH1    8'h00
`define TCI_RD_FILL        8'hFF

`endif

/* File: verilog/tci_pkg.sv */
// Types shared by the touch controller register port.
// Assumes nothing of its surroundings.
package tci_pkg;

   typedef enum logic [2:0] {
      st_idle,
      st_rx_byte,
      st_rx_ack,
      st_tx_byte,
      st_tx_ack
   } tci_state_e;

   typedef enum logic [1:0] {
      ph_addr,
      ph_ptr_hi,
      ph_ptr_lo,
      ph_data
   } tci_phase_e;

   typedef struct packed {
      logic scl;
      logic sda;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } tci_line_s;

   typedef struct packed {
      logic        en;
      logic [15:0] addr;
      logic [7:0]  data;
   } tci_wr_s;

   typedef struct packed {
      logic [7:0]  config_version;
      logic [15:0] x_resolution;
      logic [15:0] y_resolution;
      logic [7:0]  max_touch_points;
      logic [7:0]  feature_switch_one;
   } tci_cfg_s;

endpackage

/* File: verilog/tci_reg_file.sv */
// Register map behind the serial port: command byte and configuration bytes.
// Assumes one write strobe per byte from the protocol engine.
`timescale 1ns/1ps
`include "tci_params.svh"
module tci_reg_file import tci_pkg::*; (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  tci_wr_s          wr,
   input  wire logic [15:0] rd_addr,
   output logic      [7:0]  rd_data,
   output tci_cfg_s         cfg,
   output logic             cmd_strobe,
   output logic      [7:0]  cmd_value
);

   localparam int NCFG = 7;

   logic [7:0] mem [0:NCFG-1];

   function automatic logic is_cfg(input logic [15:0] a);
      return (a >= `TCI_REG_CFG_VER) && (a <= `TCI_REG_SWITCH1);
   endfunction

   function automatic logic [2:0] cfg_idx(input logic [15:0] a);
      logic [15:0] d;
      d = a - `TCI_REG_CFG_VER;
      return d[2:0];
   endfunction

   wire logic wr_cfg = wr.en && is_cfg(wr.addr);
   wire logic wr_cmd = wr.en && (wr.addr == `TCI_REG_COMMAND);
   wire logic rd_ok  = is_cfg(rd_addr);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mem[cfg_idx(`TCI_REG_CFG_VER)] <= `TCI_RST_CFG_VER;
         mem[cfg_idx(`TCI_REG_X_LO)]    <= `TCI_RST_X_LO;
         mem[cfg_idx(`TCI_REG_X_HI)]    <= `TCI_RST_X_HI;
         mem[cfg_idx(`TCI_REG_Y_LO)]    <= `TCI_RST_Y_LO;
         mem[cfg_idx(`TCI_REG_Y_HI)]    <= `TCI_RST_Y_HI;
         mem[cfg_idx(`TCI_REG_TOUCH)]   <= `TCI_RST_TOUCH;
         mem[cfg_idx(`TCI_REG_SWITCH1)] <= `TCI_RST_SWITCH1;
         cmd_strobe <= 1'b0;
         cmd_value  <= `TCI_RST_COMMAND;
      end else if (clk_en) begin
         cmd_strobe <= wr_cmd;
         if (wr_cmd) begin
            cmd_value <= wr.data;
         end
         if (wr_cfg) begin
            mem[cfg_idx(wr.addr)] <= wr.data;
         end
      end
   end

   // The command byte is write only; it and unmapped bytes read as filler.
   assign rd_data = rd_ok ? mem[cfg_idx(rd_addr)] : `TCI_RD_FILL;

   assign cfg.config_version     = mem[cfg_idx(`TCI_REG_CFG_VER)];
   assign cfg.x_resolution       = {mem[cfg_idx(`TCI_REG_X_HI)], mem[cfg_idx(`TCI_REG_X_LO)]};
   assign cfg.y_resolution       = {mem[cfg_idx(`TCI_REG_Y_HI)], mem[cfg_idx(`TCI_REG_Y_LO)]};
   assign cfg.max_touch_points   = mem[cfg_idx(`TCI_REG_TOUCH)];
   assign cfg.feature_switch_one = mem[cfg_idx(`TCI_REG_SWITCH1)];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset || !clk_en);

   a_unmapped_fill: assert property (
      (rd_addr < `TCI_REG_CFG_VER) || (rd_addr > `TCI_REG_SWITCH1) |-> rd_data == `TCI_RD_FILL)
      else $error("unmapped or command read did not return filler");

   a_x_res_write: assert property (
      wr.en && wr.addr == `TCI_REG_X_HI |=> cfg.x_resolution[15:8] == $past(wr.data))
      else $error("x resolution high byte not stored");

endmodule
